/* File: design/timeout_guard_params.svh */
// Constants for the remote signal timeout guard: register offsets, reset
// values, field positions and timing counts.
// Assumes a 50 MHz system clock and a byte-addressed register port.
`ifndef TIMEOUT_GUARD_PARAMS_SVH
`define TIMEOUT_GUARD_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define TG_NODES 16
`define TG_SHARED_BITS 16
`define TG_BITS 32
`define TG_TIMER_W 16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TG_CLK_PERIOD_NS 20
`define TG_MS_NS 1000000
`define TG_TICK_CYCLES (`TG_MS_NS / `TG_CLK_PERIOD_NS)
`define TG_LONG_MS 500
`define TG_SHORT_MS 200

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TG_REG_CTRL 8'h00
`define TG_REG_LONG 8'h04
`define TG_REG_SHORT 8'h08
`define TG_REG_CLASS 8'h0C
`define TG_REG_REARM 8'h10
`define TG_REG_NORELAY 8'h14
`define TG_REG_SEL 8'h18
`define TG_REG_BITS 8'h1C
`define TG_REG_ALIVE 8'h20
`define TG_REG_STATUS 8'h24
`define TG_REG_MASK 8'h28

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define TG_CTRL_OWN_LSB 0
`define TG_CTRL_LAST_LSB 4
`define TG_CTRL_RST 8'hF0
`define TG_ST_SHORT 0
`define TG_ST_LONG 1
`define TG_ST_LOST 2
`define TG_ST_W 3

`endif

/* File: design/timeout_guard_pkg.sv */
// Types shared by the timeout guard, its checker, the peer model and the bench.
// Assumes nothing beyond a SystemVerilog tool.
package timeout_guard_pkg;

	typedef logic [3:0] node_id_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_MERGE = 1'b1
	} merge_state_e;

endpackage : timeout_guard_pkg

/* File: design/node_state_mem.sv */
// Per-node store of received bits and rearm blocking flags.
// Assumes one writer and two independent readers in the same clock domain.
module node_state_mem #(
	parameter int W = 64,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [W-1:0] wdata_in,
	input wire logic [AW-1:0] raddr_a_in,
	output logic [W-1:0] rdata_a_out,
	input wire logic [AW-1:0] raddr_b_in,
	output logic [W-1:0] rdata_b_out
);

	logic [W-1:0] mem [DEPTH];

	// The array itself has no reset; the guard masks stale contents.
	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_a_out <= '0;
			rdata_b_out <= '0;
		end else begin
			rdata_a_out <= mem[raddr_a_in];
			rdata_b_out <= mem[raddr_b_in];
		end
	end

endmodule : node_state_mem

/* File: design/remote_signal_timeout_guard.sv */
// Receive-side supervision of bits published by peer nodes over radio or CAN.
// Assumes the link front end delivers whole checked packets, one at a time,
// synchronous to mclk_in, with the age of relayed data in milliseconds.
`include "timeout_guard_params.svh"

module remote_signal_timeout_guard #(
	parameter int NODES = `TG_NODES,
	parameter int TW = `TG_TIMER_W,
	parameter int TICK_CYCLES = `TG_TICK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	input wire timeout_guard_pkg::node_id_t rx_node_in,
	input wire logic rx_relayed_in,
	input wire logic rx_can_in,
	input wire logic [TW-1:0] rx_age_in,
	input wire logic [31:0] rx_bits_in,
	output logic relay_valid_out,
	output timeout_guard_pkg::node_id_t relay_node_out,
	output logic [TW-1:0] relay_age_out,
	output logic [15:0] relay_radio_bits_out,
	output logic [31:0] relay_can_bits_out,
	output logic tx_turn_out,
	output logic joined_out,
	output logic [31:0] sel_bits_out,
	output logic irq_out
);
	import timeout_guard_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Restart value of a timer given the age of the data.
	function automatic logic [TW-1:0] restart_val(
		input logic [TW-1:0] tmo,
		input logic [TW-1:0] age
	);
		restart_val = (age >= tmo) ? '0 : tmo - age;
	endfunction : restart_val

	// Bits of a node that are live given its two timers.
	function automatic logic [31:0] live_mask(
		input logic [31:0] cls,
		input logic s_alive,
		input logic l_alive
	);
		live_mask = (s_alive ? cls : 32'h0000_0000)
			| (l_alive ? ~cls : 32'h0000_0000);
	endfunction : live_mask

	localparam int TCW = $clog2(TICK_CYCLES + 1);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [7:0] ctrl_q, ctrl_d;
	logic [TW-1:0] long_q, long_d, short_q, short_d;
	logic [31:0] class_q, class_d, rearm_q, rearm_d;
	logic [15:0] norelay_q, norelay_d;
	node_id_t sel_q, sel_d;
	logic [`TG_ST_W-1:0] status_q, status_d, mask_q, mask_d, events;
	logic [31:0] rdata_d, sel_bits_d, sel_bits_q;
	logic irq_d;
	logic [NODES-1:0] alive_s, alive_l, exp_s, exp_l;
	logic [63:0] mem_a, mem_b;

	always_comb begin
		ctrl_d = ctrl_q;
		long_d = long_q;
		short_d = short_q;
		class_d = class_q;
		rearm_d = rearm_q;
		norelay_d = norelay_q;
		sel_d = sel_q;
		mask_d = mask_q;
		rdata_d = 32'h0000_0000;
		if (wr_in) begin
			if (addr_in == `TG_REG_CTRL) begin
				ctrl_d = wdata_in[7:0];
			end else if (addr_in == `TG_REG_LONG) begin
				long_d = wdata_in[TW-1:0];
			end else if (addr_in == `TG_REG_SHORT) begin
				short_d = wdata_in[TW-1:0];
			end else if (addr_in == `TG_REG_CLASS) begin
				class_d = wdata_in;
			end else if (addr_in == `TG_REG_REARM) begin
				rearm_d = wdata_in;
			end else if (addr_in == `TG_REG_NORELAY) begin
				norelay_d = wdata_in[15:0];
			end else if (addr_in == `TG_REG_SEL) begin
				sel_d = wdata_in[3:0];
			end else if (addr_in == `TG_REG_MASK) begin
				mask_d = wdata_in[`TG_ST_W-1:0];
			end
		end
		if (rd_in) begin
			if (addr_in == `TG_REG_CTRL) begin
				rdata_d = {24'h00_0000, ctrl_q};
			end else if (addr_in == `TG_REG_LONG) begin
				rdata_d = 32'(long_q);
			end else if (addr_in == `TG_REG_SHORT) begin
				rdata_d = 32'(short_q);
			end else if (addr_in == `TG_REG_CLASS) begin
				rdata_d = class_q;
			end else if (addr_in == `TG_REG_REARM) begin
				rdata_d = rearm_q;
			end else if (addr_in == `TG_REG_NORELAY) begin
				rdata_d = {16'h0000, norelay_q};
			end else if (addr_in == `TG_REG_SEL) begin
				rdata_d = {28'h000_0000, sel_q};
			end else if (addr_in == `TG_REG_BITS) begin
				rdata_d = sel_bits_q;
			end else if (addr_in == `TG_REG_ALIVE) begin
				rdata_d = {16'(alive_l), 16'(alive_s)};
			end else if (addr_in == `TG_REG_STATUS) begin
				rdata_d = 32'(status_q);
			end else if (addr_in == `TG_REG_MASK) begin
				rdata_d = 32'(mask_q);
			end
		end
		// A read clears the status, but an event in the same cycle survives.
		status_d = status_q;
		if (rd_in && addr_in == `TG_REG_STATUS) begin
			status_d = '0;
		end
		status_d = status_d | events;
		irq_d = |(status_d & mask_q);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_q <= `TG_CTRL_RST;
			long_q <= TW'(`TG_LONG_MS);
			short_q <= TW'(`TG_SHORT_MS);
			class_q <= 32'h0000_0000;
			rearm_q <= 32'h0000_0000;
			norelay_q <= 16'h0000;
			sel_q <= 4'h0;
			mask_q <= '0;
			status_q <= '0;
			rdata_out <= 32'h0000_0000;
			irq_out <= 1'b0;
			sel_bits_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			long_q <= long_d;
			short_q <= short_d;
			class_q <= class_d;
			rearm_q <= rearm_d;
			norelay_q <= norelay_d;
			sel_q <= sel_d;
			mask_q <= mask_d;
			status_q <= status_d;
			rdata_out <= rdata_d;
			irq_out <= irq_d;
			sel_bits_q <= sel_bits_d;
		end
	end

	assign sel_bits_out = sel_bits_q;

	// ------------------------------------------------------------------
	// Millisecond tick
	// ------------------------------------------------------------------
	logic [TCW-1:0] tick_cnt_q, tick_cnt_d;
	logic tick;

	always_comb begin
		tick = (tick_cnt_q == TCW'(TICK_CYCLES - 1));
		tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// Packet merge
	// ------------------------------------------------------------------
	merge_state_e state_q, state_d;
	node_id_t node_q, node_d;
	logic relayed_q, relayed_d, can_q, can_d;
	logic [TW-1:0] age_q, age_d;
	logic [31:0] bits_q, bits_d;
	logic commit, ready_d, relay_valid_d, turn_d;
	logic [NODES-1:0] pend_s_q, pend_l_q, pend_s_d, pend_l_d;
	logic [31:0] arm, carried, blk_new, bits_new, old_blk, old_bits;
	logic [63:0] wdata;
	node_id_t prev_node;

	always_comb begin
		state_d = state_q;
		node_d = node_q;
		relayed_d = relayed_q;
		can_d = can_q;
		age_d = age_q;
		bits_d = bits_q;
		commit = (state_q == ST_MERGE);
		if (state_q == ST_IDLE) begin
			if (rx_valid_in && rx_ready_out) begin
				state_d = ST_MERGE;
				node_d = rx_node_in;
				relayed_d = rx_relayed_in;
				can_d = rx_can_in;
				age_d = rx_relayed_in ? rx_age_in : '0;
				bits_d = rx_bits_in;
			end
		end else begin
			state_d = ST_IDLE;
		end
		ready_d = (state_d == ST_IDLE);
		// Radio carries only the shared half; relayed copies of
		// suppressed bits are not trusted and leave the old value.
		carried = can_q ? 32'hFFFF_FFFF : 32'h0000_FFFF;
		if (relayed_q) begin
			carried = carried & ~{16'h0000, norelay_q};
		end
		arm = (pend_s_q[node_q] ? class_q : 32'h0000_0000)
			| (pend_l_q[node_q] ? ~class_q : 32'h0000_0000);
		// Arming forgets what was stored, so a row never written since
		// reset cannot leak into the merge.
		old_blk = (mem_a[63:32] & ~arm) | (rearm_q & arm);
		old_bits = mem_a[31:0] & ~arm;
		// A blocked bit is released by an explicit 0, or by arming while its rearm bit is 0.
		blk_new = (old_blk & bits_q & carried)
			| (old_blk & ~carried);
		bits_new = ((bits_q & carried) | (old_bits & ~carried))
			& ~blk_new;
		wdata = {blk_new, bits_new};
		relay_valid_d = commit;
		prev_node = (ctrl_q[3:0] == 4'h0) ? ctrl_q[7:4]
			: ctrl_q[3:0] - 4'h1;
		turn_d = commit && !relayed_q && node_q == prev_node;
		sel_bits_d = mem_b[31:0] & live_mask(class_q, alive_s[sel_q],
			alive_l[sel_q]);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= ST_IDLE;
			node_q <= 4'h0;
			relayed_q <= 1'b0;
			can_q <= 1'b0;
			age_q <= '0;
			bits_q <= 32'h0000_0000;
			rx_ready_out <= 1'b0;
			relay_valid_out <= 1'b0;
			relay_node_out <= 4'h0;
			relay_age_out <= '0;
			relay_radio_bits_out <= 16'h0000;
			relay_can_bits_out <= 32'h0000_0000;
			tx_turn_out <= 1'b0;
			pend_s_q <= '1;
			pend_l_q <= '1;
		end else begin
			state_q <= state_d;
			node_q <= node_d;
			relayed_q <= relayed_d;
			can_q <= can_d;
			age_q <= age_d;
			bits_q <= bits_d;
			rx_ready_out <= ready_d;
			relay_valid_out <= relay_valid_d;
			tx_turn_out <= turn_d;
			pend_s_q <= pend_s_d;
			pend_l_q <= pend_l_d;
			if (commit) begin
				relay_node_out <= node_q;
				relay_age_out <= age_q;
				relay_radio_bits_out <= bits_q[15:0] & ~norelay_q;
				relay_can_bits_out <= (can_q ? bits_q : {16'h0000, bits_q[15:0]})
					& ~{16'h0000, norelay_q};
			end
		end
	end

	node_state_mem #(
		.W(64),
		.DEPTH(NODES),
		.AW(4)
	) u_mem (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.we_in(commit),
		.waddr_in(node_q),
		.wdata_in(wdata),
		.raddr_a_in(rx_node_in),
		.rdata_a_out(mem_a),
		.raddr_b_in(sel_q),
		.rdata_b_out(mem_b)
	);

	// ------------------------------------------------------------------
	// Per-node timers
	// ------------------------------------------------------------------
	for (genvar g = 0; g < NODES; g++) begin : g_node
		logic [TW-1:0] ts_q, ts_d, tl_q, tl_d;
		logic load;

		always_comb begin
			load = commit && node_q == 4'(g);
			ts_d = ts_q;
			tl_d = tl_q;
			if (load) begin
				ts_d = restart_val(short_q, age_q);
				tl_d = restart_val(long_q, age_q);
			end else if (tick) begin
				if (ts_q != '0) begin
					ts_d = ts_q - 1'b1;
				end
				if (tl_q != '0) begin
					tl_d = tl_q - 1'b1;
				end
			end
		end

		always_ff @(posedge mclk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				ts_q <= '0;
				tl_q <= '0;
			end else begin
				ts_q <= ts_d;
				tl_q <= tl_d;
			end
		end

		assign alive_s[g] = (ts_q != '0);
		assign alive_l[g] = (tl_q != '0);
		assign exp_s[g] = alive_s[g] && ts_d == '0;
		assign exp_l[g] = alive_l[g] && tl_d == '0;
		// Fresh data wins over an expiry in the same cycle.
		assign pend_s_d[g] = load ? 1'b0 : (pend_s_q[g] | exp_s[g]);
		assign pend_l_d[g] = load ? 1'b0 : (pend_l_q[g] | exp_l[g]);
	end

	// ------------------------------------------------------------------
	// Network membership and events
	// ------------------------------------------------------------------
	logic joined_d;

	always_comb begin
		joined_d = alive_l[0] | alive_s[0];
		events = '0;
		events[`TG_ST_SHORT] = |exp_s;
		events[`TG_ST_LONG] = |exp_l;
		events[`TG_ST_LOST] = joined_out && !joined_d;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			joined_out <= 1'b0;
		end else begin
			joined_out <= joined_d;
		end
	end

endmodule : remote_signal_timeout_guard

/* File: bench/tg_checker_properties.sv */
// Port-level checks of the timeout guard's packet and relay behaviour.
// Assumes it is bound to the guard's top module, one clock domain.
module tg_checker_properties import timeout_guard_pkg::*; #(
	parameter int TW = 16
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic rx_valid_in,
	input wire logic rx_ready_out,
	input wire timeout_guard_pkg::node_id_t rx_node_in,
	input wire logic rx_relayed_in,
	input wire logic rx_can_in,
	input wire logic [TW-1:0] rx_age_in,
	input wire logic [31:0] rx_bits_in,
	input wire logic relay_valid_out,
	input wire timeout_guard_pkg::node_id_t relay_node_out,
	input wire logic [TW-1:0] relay_age_out,
	input wire logic [15:0] relay_radio_bits_out,
	input wire logic [31:0] relay_can_bits_out,
	input wire logic joined_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_take;
		rx_valid_in && rx_ready_out;
	endsequence
	sequence s_pause;
		!rx_ready_out ##1 rx_ready_out;
	endsequence
	property p_ready_drop;
		s_take |=> s_pause;
	endproperty
	a_ready_drop: assert property (p_ready_drop)
		else $error("packet port not paused for one cycle");
	property p_relay_pulse;
		s_take |-> ##2 relay_valid_out ##1 !relay_valid_out;
	endproperty
	a_relay_pulse: assert property (p_relay_pulse)
		else $error("relay pulse missing or too long");
	property p_relay_node;
		s_take |-> ##2 relay_node_out == $past(rx_node_in, 2);
	endproperty
	a_relay_node: assert property (p_relay_node)
		else $error("relayed owner differs");
	property p_relay_age;
		s_take and rx_relayed_in |-> ##2 relay_age_out == $past(rx_age_in, 2);
	endproperty
	a_relay_age: assert property (p_relay_age)
		else $error("relayed age not passed on");
	property p_radio_only;
		s_take and !rx_can_in |-> ##2 relay_can_bits_out[31:16] == 16'h0;
	endproperty
	a_radio_only: assert property (p_radio_only)
		else $error("radio packet relayed CAN-only bits");
	property p_suppress;
		s_take |-> ##2
			(relay_radio_bits_out & ~$past(rx_bits_in[15:0], 2)) == 16'h0;
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("relay carries bits never received");
	property p_halves;
		relay_valid_out |-> relay_radio_bits_out == relay_can_bits_out[15:0];
	endproperty
	a_halves: assert property (p_halves)
		else $error("shared half differs between links");
	property p_rdata_idle;
		!rd_in |=> rdata_out == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	property p_join;
		s_take and rx_node_in == 4'h0 and !rx_relayed_in |-> ##[1:3] joined_out;
	endproperty
	a_join: assert property (p_join)
		else $error("first node heard but not joined");
endmodule : tg_checker_properties

bind remote_signal_timeout_guard tg_checker_properties #(.TW(TW)) u_chk (
	.mclk_in, .rst_b_in, .rd_in, .rdata_out, .rx_valid_in, .rx_ready_out,
	.rx_node_in, .rx_relayed_in, .rx_can_in, .rx_age_in, .rx_bits_in,
	.relay_valid_out, .relay_node_out, .relay_age_out, .relay_radio_bits_out,
	.relay_can_bits_out, .joined_out
);

/* File: bench/peer_node_model.sv */
// Peer node that offers checked packets to the guard's packet port.
// Assumes the caller invokes send just after a rising clock edge.
module peer_node_model import timeout_guard_pkg::*; (
	input wire logic mclk_in,
	input wire logic ready_in,
	output logic valid_out,
	output timeout_guard_pkg::node_id_t node_out,
	output logic relayed_out,
	output logic can_out,
	output logic [15:0] age_out,
	output logic [31:0] bits_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		valid_out = 1'b0;
		node_out = '0;
		relayed_out = 1'b0;
		can_out = 1'b0;
		age_out = '0;
		bits_out = '0;
	end
	// Whole set in one offer; released lines show the inverse, never stale.
	task automatic send(input node_id_t n, input logic rel, input logic can,
		input logic [15:0] age, input logic [31:0] b, input int gap);
		repeat (gap + 1) @(posedge mclk_in);
		valid_out <= 1'b1;
		node_out <= n;
		relayed_out <= rel;
		can_out <= can;
		age_out <= age;
		bits_out <= b;
		do @(posedge mclk_in); while (ready_in !== 1'b1);
		valid_out <= 1'b0;
		node_out <= ~n;
		relayed_out <= ~rel;
		can_out <= ~can;
		age_out <= ~age;
		bits_out <= ~b;
	endtask : send
endmodule : peer_node_model

/* File: bench/remote_signal_timeout_guard_bench.sv */
// Self-checking bench for the timeout guard, peer model on the packet port.
// Assumes a 10-cycle ms tick so timeouts of a few ms run quickly.
`include "timeout_guard_params.svh"
module remote_signal_timeout_guard_bench import timeout_guard_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] NR = 32'h0000_010F;
	// Own node index 3, so index 2 is the node that sends just before us.
	localparam node_id_t PREV = 4'h2;
	logic mclk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0, rd_seen = 0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0, rdata_out, rx_bits_in, b1;
	logic [31:0] relay_can_bits_out, sel_bits_out;
	logic rx_valid_in, rx_ready_out, rx_relayed_in, rx_can_in;
	logic relay_valid_out, tx_turn_out, joined_out, irq_out;
	node_id_t rx_node_in, relay_node_out;
	logic [15:0] rx_age_in, relay_age_out, relay_radio_bits_out;
	logic [31:0] rq[$];
	logic [20:0] pq[$];
	logic [20:0] relay_seen;
	int num_errors = 0, checks_done = 0, cycles = 0, seed = 37239;
	initial forever #10 mclk_in = ~mclk_in;
	remote_signal_timeout_guard #(.TICK_CYCLES(10)) dut (.mclk_in, .rst_b_in,
		.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_valid_in,
		.rx_ready_out, .rx_node_in, .rx_relayed_in, .rx_can_in, .rx_age_in,
		.rx_bits_in, .relay_valid_out, .relay_node_out, .relay_age_out,
		.relay_radio_bits_out, .relay_can_bits_out, .tx_turn_out, .joined_out,
		.sel_bits_out, .irq_out);
	peer_node_model peer (.mclk_in, .ready_in(rx_ready_out),
		.valid_out(rx_valid_in), .node_out(rx_node_in),
		.relayed_out(rx_relayed_in), .can_out(rx_can_in),
		.age_out(rx_age_in), .bits_out(rx_bits_in));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in) wr_in <= 1'b0;
		@(posedge mclk_in);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in) rd_in <= 1'b0;
		@(posedge mclk_in);
	endtask : rd
	// Relay output is expected with the suppressed shared bits removed.
	task pkt(input node_id_t n, input logic rel, input logic can,
		input logic [15:0] age, input logic [31:0] b);
		pq.push_back({!rel && n == PREV, n, b[15:0] & ~NR[15:0]});
		peer.send(n, rel, can, age, b, $random(seed) & 3);
		repeat (4) @(posedge mclk_in);
	endtask : pkt
	always @(posedge mclk_in) begin
		if (rd_seen) check(rdata_out, rq.pop_front());
		rd_seen = rd_in;
		relay_seen = {tx_turn_out, relay_node_out, relay_radio_bits_out};
		if (relay_valid_out) check(relay_seen, pq.pop_front());
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (16) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		@(posedge mclk_in);
		rd(`TG_REG_LONG, 32'd500);
		rd(`TG_REG_SHORT, 32'd200);
		rd(8'h30, 32'h0);
		rd(`TG_REG_CTRL, 32'h0000_00F0);
		wr(`TG_REG_CTRL, 32'h0000_00F3);
		wr(`TG_REG_LONG, 32'd20);
		wr(`TG_REG_SHORT, 32'd8);
		wr(`TG_REG_CLASS, 32'h0000_00FF);
		wr(`TG_REG_REARM, 32'h0000_0100);
		wr(`TG_REG_NORELAY, NR);
		wr(`TG_REG_MASK, 32'h3);
		wr(`TG_REG_SEL, 32'h2);
		b1 = $random(seed) & ~32'h100;
		pkt(4'h2, 1'b0, 1'b1, 16'h0, b1 | 32'h100);
		check(sel_bits_out, b1);
		pkt(4'h2, 1'b0, 1'b1, 16'h0, b1);
		pkt(4'h2, 1'b0, 1'b1, 16'h0, b1 | 32'h100);
		rd(`TG_REG_BITS, b1 | 32'h100);
		rd(`TG_REG_ALIVE, 32'h0004_0004);
		repeat (100) @(posedge mclk_in);
		rd(`TG_REG_BITS, (b1 | 32'h100) & ~32'hFF);
		check(irq_out, 32'h1);
		rd(`TG_REG_STATUS, 32'h1);
		@(posedge mclk_in);
		check(irq_out, 32'h0);
		repeat (130) @(posedge mclk_in);
		rd(`TG_REG_BITS, 32'h0);
		rd(`TG_REG_STATUS, 32'h2);
		pkt(4'h2, 1'b0, 1'b1, 16'h0, b1 | 32'h100);
		rd(`TG_REG_BITS, b1);
		wr(`TG_REG_SEL, 32'h3);
		pkt(4'h3, 1'b1, 1'b1, 16'd10, b1 | NR);
		rd(`TG_REG_ALIVE, 32'h000C_0004);
		rd(`TG_REG_BITS, b1 & 32'hFFFF_FE00);
		pkt(4'h3, 1'b0, 1'b0, 16'h0, ~b1);
		rd(`TG_REG_BITS, {b1[31:16], ~b1[15:0]} & ~32'h100);
		for (int i = 0; i < 8; i++)
			pkt(i == 0 ? 4'h0 : 4'($random(seed)), i != 0 && $random(seed) % 2,
				1'($random(seed)), 16'($random(seed) & 31), $random(seed));
		repeat (10) @(posedge mclk_in);
		stop_test();
	end
endmodule : remote_signal_timeout_guard_bench
